// *** hw/pag_port.sv ***
// Summary of operation
// RULE1: direction 1 input hi-z, 0 drives latch
// RULE2: pin read gives levels, write hits latch
// RULE3: latch register readable for read-modify-write
// RULE4: bits 6,7 read zero when not port
// RULE5: bit 6 port only in IO modes
// RULE6: bit 7 port only in internal modes
// RULE7: converter config selects analog or digital
// RULE8: analog after reset, analog reads zero
// RULE9: latch drive ignores analog configuration
// RULE10: software keeps analog pins as inputs
// RULE11: enabled segment overrides port output
// RULE12: fixed mapping pins 4,5,2,3 to 14-17
// RULE13: bit 4 open drain, timer clock
// RULE14: bits 5,2,3 feed detector and references
// RULE15: pin levels pass two-flop synchroniser
//
// The Avalon-MM interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module pag_port (
    input  wire logic                          ref_clk,
    input  wire logic                          rst_b,
    input  wire logic [pag_pkg::ADDR_W-1:0]    avs_address,
    input  wire logic                          avs_read,
    input  wire logic                          avs_write,
    input  wire logic [pag_pkg::DATA_W-1:0]    avs_writedata,
    input  wire logic [3:0]                    avs_byteenable,
    output var  logic [pag_pkg::DATA_W-1:0]    avs_readdata,
    output var  logic                          avs_waitrequest,
    output var  logic [1:0]                    avs_response,
    input  wire pag_pkg::pag_osc_t             osc_mode,
    input  wire logic [pag_pkg::PORT_W-1:0]    pin_in,
    output var  pag_pkg::pag_pins_t            pins,
    output var  logic                          timer_zero_ext_clock,
    output var  logic [pag_pkg::PORT_W-1:0]    analog_pins,
    output var  logic [pag_pkg::PORT_W-1:0]    segment_pins
);

    logic [pag_pkg::PORT_W-1:0] port_output_latch;
    logic [pag_pkg::PORT_W-1:0] port_direction;
    logic [pag_pkg::PORT_W-1:0] converter_pin_config;
    logic [pag_pkg::PORT_W-1:0] segment_enable_low;
    logic [pag_pkg::PORT_W-1:0] segment_enable_high;
    logic [pag_pkg::PORT_W-1:0] sync_first;
    logic [pag_pkg::PORT_W-1:0] sync_second;
    logic [pag_pkg::DIV_W-1:0]  cycle_div;
    logic                       port_six_en;
    logic                       port_seven_en;
    logic [pag_pkg::PORT_W-1:0] port_mask;
    logic [pag_pkg::PORT_W-1:0] analog_now;
    logic [pag_pkg::PORT_W-1:0] seg_now;
    logic [pag_pkg::PORT_W-1:0] rd_byte;
    logic                       rd_hit;
    logic                       wr_take;
    logic [pag_pkg::PORT_W-1:0] wr_byte;
    pag_pkg::pag_pins_t         next_pins;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////////////////////////////////////////////
    // Oscillator-dependent pin ownership

    always_comb begin
        port_six_en   = 1'b0;
        port_seven_en = 1'b0;
        unique case (osc_mode)
            pag_pkg::OSC_RC_WITH_IO,
            pag_pkg::OSC_EXT_CLOCK_WITH_IO: begin
                // RULE5: bit 6 port
                port_six_en = 1'b1;
            end
            pag_pkg::OSC_INT_IO_TWO: begin
                port_six_en   = 1'b1;
                // RULE6: internal modes own bit 7
                port_seven_en = 1'b1;
            end
            pag_pkg::OSC_INT_IO_ONE: begin
                port_seven_en = 1'b1;
            end
            pag_pkg::OSC_LOW_POWER,
            pag_pkg::OSC_CRYSTAL,
            pag_pkg::OSC_HIGH_SPEED,
            pag_pkg::OSC_RC,
            pag_pkg::OSC_EXT_CLOCK: begin
                port_six_en = 1'b0;
            end
            default: begin
                port_six_en = 1'b0;
            end
        endcase
        port_mask = {port_seven_en, port_six_en, pag_pkg::LOW_MASK};
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Analog and segment selection

    always_comb begin
        analog_now = pag_pkg::ZERO_B;
        for (int k = 0; k < pag_pkg::ANA_CH; k++) begin
            // RULE7: config field selects analog
            // RULE14: references and trip input
            analog_now[pag_pkg::ANA_PIN[k]] =
                converter_pin_config[pag_pkg::ANA_LSB +: pag_pkg::ANA_W] < pag_pkg::ANA_LIMIT[k];
        end
    end

    always_comb begin
        seg_now = pag_pkg::ZERO_B;
        // RULE12: fixed segment mapping
        seg_now[pag_pkg::BIT_OD]      = segment_enable_low[pag_pkg::SEG_LO_FOURTEEN];
        seg_now[pag_pkg::BIT_TRIP]    = segment_enable_low[pag_pkg::SEG_LO_FIFTEEN];
        seg_now[pag_pkg::BIT_VREF_LO] = segment_enable_high[pag_pkg::SEG_HI_SIXTEEN];
        seg_now[pag_pkg::BIT_VREF_HI] = segment_enable_high[pag_pkg::SEG_HI_SEVENTEEN];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin input synchroniser

    // RULE15: two-flop synchroniser
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_first  <= pag_pkg::ZERO_B;
            sync_second <= pag_pkg::ZERO_B;
        end else begin
            sync_first  <= pin_in;
            sync_second <= sync_first;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Avalon slave: one wait cycle, then answer

    assign wr_take = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign wr_byte = avs_writedata[pag_pkg::PORT_W-1:0];

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
        end
    end

    always_comb begin
        rd_hit  = 1'b1;
        rd_byte = pag_pkg::ZERO_B;
        case (avs_address)
            // RULE2: pin levels read
            // RULE8: analog pins read zero
            // RULE4: unowned bits read zero
            pag_pkg::OFS_PIN:    rd_byte = sync_second & ~analog_now & port_mask;
            // RULE3: latch read back
            pag_pkg::OFS_LAT:    rd_byte = port_output_latch & port_mask;
            pag_pkg::OFS_DIR:    rd_byte = port_direction & port_mask;
            pag_pkg::OFS_CFG:    rd_byte = converter_pin_config & pag_pkg::CFG_MASK;
            pag_pkg::OFS_SEG_LO: rd_byte = segment_enable_low;
            pag_pkg::OFS_SEG_HI: rd_byte = segment_enable_high;
            default:             rd_hit  = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            avs_readdata <= {pag_pkg::ZERO_HI, pag_pkg::ZERO_B};
            avs_response <= pag_pkg::RESP_OKAY;
        end else if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_readdata <= {pag_pkg::ZERO_HI, avs_read ? rd_byte : pag_pkg::ZERO_B};
            avs_response <= rd_hit ? pag_pkg::RESP_OKAY : pag_pkg::RESP_SLVERR;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            port_output_latch <= pag_pkg::RST_LAT;
        end else if (wr_take && (avs_address == pag_pkg::OFS_PIN ||
                                 avs_address == pag_pkg::OFS_LAT)) begin
            // RULE2: pin write lands in latch
            port_output_latch <= wr_byte;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            port_direction <= pag_pkg::RST_DIR;
        end else if (wr_take && avs_address == pag_pkg::OFS_DIR) begin
            port_direction <= wr_byte;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            // RULE8: analog after reset
            converter_pin_config <= pag_pkg::RST_CFG;
        end else if (wr_take && avs_address == pag_pkg::OFS_CFG) begin
            converter_pin_config <= wr_byte & pag_pkg::CFG_MASK;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            segment_enable_low  <= pag_pkg::RST_SEG;
            segment_enable_high <= pag_pkg::RST_SEG;
        end else if (wr_take && avs_address == pag_pkg::OFS_SEG_LO) begin
            segment_enable_low  <= wr_byte;
        end else if (wr_take && avs_address == pag_pkg::OFS_SEG_HI) begin
            segment_enable_high <= wr_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin drivers

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cycle_div <= '0;
        end else begin
            cycle_div <= cycle_div + pag_pkg::DIV_ONE;
        end
    end

    always_comb begin
        for (int i = 0; i < pag_pkg::PORT_W; i++) begin
            // RULE1: direction drives latch
            // RULE9: analog select ignored here
            // RULE11: segment disables port drive
            next_pins.out[i] = port_output_latch[i];
            next_pins.oe[i]  = !port_direction[i] && !seg_now[i];
        end
        // RULE13: open drain low only
        next_pins.out[pag_pkg::BIT_OD] = 1'b0;
        next_pins.oe[pag_pkg::BIT_OD]  = !port_direction[pag_pkg::BIT_OD] &&
                                         !seg_now[pag_pkg::BIT_OD] &&
                                         !port_output_latch[pag_pkg::BIT_OD];
        if (!port_six_en) begin
            // RULE5: cycle clock output
            next_pins.out[pag_pkg::BIT_CYC_OUT] = cycle_div[pag_pkg::DIV_W-1];
            next_pins.oe[pag_pkg::BIT_CYC_OUT]  = 1'b1;
        end
        if (!port_seven_en) begin
            // RULE6: oscillator input pin
            next_pins.out[pag_pkg::BIT_OSCI] = 1'b0;
            next_pins.oe[pag_pkg::BIT_OSCI]  = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pins.out             <= pag_pkg::ZERO_B;
            pins.oe              <= pag_pkg::ZERO_B;
            timer_zero_ext_clock <= 1'b0;
            analog_pins          <= pag_pkg::ZERO_B;
            segment_pins         <= pag_pkg::ZERO_B;
        end else begin
            pins                 <= next_pins;
            // RULE13: timer clock input
            timer_zero_ext_clock <= sync_second[pag_pkg::BIT_OD];
            analog_pins          <= analog_now;
            segment_pins         <= seg_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    dir_hiz_a: // RULE1
    assert property ($past(port_direction[0]) |-> !pins.oe[0])
        else $error("input pin is driven");

    drive_latch_a: // RULE9
    assert property (!$past(port_direction[1]) |-> pins.oe[1] && pins.out[1] == $past(port_output_latch[1]))
        else $error("output pin does not carry latch");

    pin_write_a: // RULE2
    assert property (avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == pag_pkg::OFS_PIN
                     |=> port_output_latch == $past(avs_writedata[7:0]))
        else $error("pin write missed latch");

    latch_read_a: // RULE3
    assert property (avs_read && avs_waitrequest && avs_address == pag_pkg::OFS_LAT
                     |=> !avs_waitrequest && avs_readdata[5:0] == $past(port_output_latch[5:0]))
        else $error("latch read mismatch");

    osc_bits_zero_a: // RULE4
    assert property (avs_read && avs_waitrequest && avs_address == pag_pkg::OFS_DIR && !port_six_en
                     |=> avs_readdata[6] == 1'b0)
        else $error("bit 6 direction not zero");

    clk_out_a: // RULE5
    assert property (($past(rst_b) && !port_six_en) ##1 !port_six_en ##1 !port_six_en ##1 !port_six_en
                     |-> pins.oe[6] && pins.out[6] != $past(pins.out[6], 2))
        else $error("cycle clock not driven");

    osc_in_a: // RULE6
    assert property ($past(!port_seven_en) |-> !pins.oe[7])
        else $error("oscillator input driven");

    analog_zero_a: // RULE8
    assert property (avs_read && avs_waitrequest && avs_address == pag_pkg::OFS_PIN && analog_now[0]
                     |=> avs_readdata[0] == 1'b0)
        else $error("analog pin read nonzero");

    seg_override_a: // RULE11
    assert property ($past(segment_enable_high[1]) |-> !pins.oe[3])
        else $error("segment pin still driven");

    open_drain_a: // RULE13
    assert property (pins.oe[4] |-> !pins.out[4] && !$past(port_output_latch[4]))
        else $error("open drain drove high");

    sync_path_a: // RULE15
    assert property (avs_read && avs_waitrequest && avs_address == pag_pkg::OFS_PIN
                     |=> avs_readdata[4] == $past(pin_in[4], 3))
        else $error("pin read not synchronised");

    cfg_digital_a: // RULE7
    assert property ($past(converter_pin_config[3:0] == 4'hF) |-> analog_pins == 8'h00)
        else $error("analog select ignored");

endmodule : pag_port

`default_nettype wire

// *** hw/pag_pkg.sv ***
`default_nettype none

package pag_pkg;

    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned PORT_W = 8;
    localparam int unsigned ANA_CH = 5;

    // Byte offsets of the register words
    localparam logic [ADDR_W-1:0] OFS_PIN    = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_LAT    = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_DIR    = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_CFG    = 5'h0C;
    localparam logic [ADDR_W-1:0] OFS_SEG_LO = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_SEG_HI = 5'h14;

    // Reset values
    localparam logic [PORT_W-1:0] RST_DIR = 8'hFF;
    localparam logic [PORT_W-1:0] RST_LAT = 8'h00;
    localparam logic [PORT_W-1:0] RST_CFG = 8'h00;
    localparam logic [PORT_W-1:0] RST_SEG = 8'h00;
    localparam logic [PORT_W-1:0] ZERO_B  = 8'h00;
    localparam logic [23:0]       ZERO_HI = 24'h000000;

    // Converter config: bits 7:6 unimplemented, analog select field in 3:0
    localparam logic [PORT_W-1:0] CFG_MASK = 8'h3F;
    localparam int unsigned       ANA_LSB  = 0;
    localparam int unsigned       ANA_W    = 4;
    // Channel k is analog while field is below its limit
    localparam logic [ANA_W-1:0]  ANA_LIMIT [ANA_CH] = '{4'hF, 4'hE, 4'hD, 4'hC, 4'hB};
    localparam logic [2:0]        ANA_PIN   [ANA_CH] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5};

    // Pins 5:0 always port pins; 7:6 depend on oscillator mode
    localparam logic [5:0]        LOW_MASK = 6'h3F;

    // Special pin positions
    localparam int unsigned BIT_VREF_LO = 2;
    localparam int unsigned BIT_VREF_HI = 3;
    localparam int unsigned BIT_OD      = 4;
    localparam int unsigned BIT_TRIP    = 5;
    localparam int unsigned BIT_CYC_OUT = 6;
    localparam int unsigned BIT_OSCI    = 7;

    // Segment enable bit positions
    localparam int unsigned SEG_LO_FOURTEEN  = 6;
    localparam int unsigned SEG_LO_FIFTEEN   = 7;
    localparam int unsigned SEG_HI_SIXTEEN   = 0;
    localparam int unsigned SEG_HI_SEVENTEEN = 1;

    // Cycle clock divider: oscillator over four
    localparam int unsigned     DIV_W   = 2;
    localparam logic [DIV_W-1:0] DIV_ONE = 2'h1;

    // Avalon response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        OSC_LOW_POWER         = 4'h0,
        OSC_CRYSTAL           = 4'h1,
        OSC_HIGH_SPEED        = 4'h2,
        OSC_RC                = 4'h3,
        OSC_RC_WITH_IO        = 4'h4,
        OSC_EXT_CLOCK         = 4'h5,
        OSC_EXT_CLOCK_WITH_IO = 4'h6,
        OSC_INT_IO_ONE        = 4'h7,
        OSC_INT_IO_TWO        = 4'h8
    } pag_osc_t;

    typedef struct packed {
        logic [PORT_W-1:0] out;
        logic [PORT_W-1:0] oe;
    } pag_pins_t;

endpackage : pag_pkg

`default_nettype wire

// *** test/pag_pins_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module pag_pins_model (
    input  wire pag_pkg::pag_pins_t         pins,
    input  wire logic [pag_pkg::PORT_W-1:0] ext_en,
    input  wire logic [pag_pkg::PORT_W-1:0] ext_val,
    output var  logic [pag_pkg::PORT_W-1:0] pin_in
);
    // Wire level: device drive, else board drive, else board pull-up
    // open drain pull-up
    always_comb begin
        for (int i = 0; i < pag_pkg::PORT_W; i++) begin
            if (pins.oe[i]) pin_in[i] = pins.out[i];
            else if (ext_en[i]) pin_in[i] = ext_val[i];
            else pin_in[i] = 1'b1;
        end
    end
endmodule : pag_pins_model

`default_nettype wire

// *** test/pag_port_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end

module pag_port_tb;
    logic                   ref_clk, rst_b, rd, wr;
    logic [4:0]             adr;
    logic [31:0]            wdat, rdat;
    logic                   wait_r, tclk;
    logic [1:0]             resp;
    pag_pkg::pag_osc_t      osc;
    logic [7:0]             pin_in, ana, seg, ext_en, ext_val, d;
    pag_pkg::pag_pins_t     pins;
    int                     num_errors, cmp_count, waits;

    pag_port pag_port_i (.ref_clk(ref_clk), .rst_b(rst_b), .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(4'hF),
        .avs_readdata(rdat), .avs_waitrequest(wait_r), .avs_response(resp),
        .osc_mode(osc), .pin_in(pin_in), .pins(pins), .timer_zero_ext_clock(tclk),
        .analog_pins(ana), .segment_pins(seg));
    pag_pins_model pag_pins_model_i (.pins(pins), .ext_en(ext_en), .ext_val(ext_val),
        .pin_in(pin_in));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic stop_test();
        if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] v,
                       output logic [7:0] q);
        waits = 0;
        @(posedge ref_clk);
        adr <= a; rd <= ~w; wr <= w; wdat <= {24'h000000, v};
        do begin
            @(posedge ref_clk);
            waits++;
        end while (wait_r !== 1'b0);
        q = rdat[7:0];
        rd <= 1'b0; wr <= 1'b0;
    endtask : bus

    task automatic wr8(input logic [4:0] a, input logic [7:0] v);
        bus(1'b1, a, v, d);
    endtask : wr8

    task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00, d);
        `CHK("readdata", e, d)
    endtask : rdchk

    task automatic settle();
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : settle

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        settle();
        `CHK("oe", 8'h00, pins.oe)
        rdchk(5'h08, 8'hFF);
        rdchk(5'h04, 8'h00);
        rdchk(5'h10, 8'h00);
        rdchk(5'h00, 8'hD0);
        `CHK("ana", 8'h2F, ana)
    endtask : t_reset

    task automatic t_latch();
        wr8(5'h0C, 8'h0F);
        ext_en <= 8'h00;
        wr8(5'h00, 8'hA5);
        rdchk(5'h04, 8'hA5);
        wr8(5'h08, 8'h00);
        settle();
        `CHK("oe", 8'hFF, pins.oe)
        `CHK("out", 8'hA5, pins.out)
        `CHK("t0", 1'b0, tclk)
        bus(1'b0, 5'h04, 8'h00, d);
        wr8(5'h04, d | 8'h10);
        settle();
        `CHK("oe4", 8'hEF, pins.oe)
        `CHK("out4", 8'hA5, pins.out)
        `CHK("t0", 1'b1, tclk)
        rdchk(5'h00, 8'hB5);
    endtask : t_latch

    task automatic t_seg();
        logic [7:0] lo [4] = '{8'h40, 8'h80, 8'h00, 8'h00};
        logic [7:0] hi [4] = '{8'h00, 8'h00, 8'h01, 8'h02};
        int         p [4]  = '{4, 5, 2, 3};
        wr8(5'h04, 8'h05);
        for (int k = 0; k < 4; k++) begin
            wr8(5'h10, lo[k]);
            wr8(5'h14, hi[k]);
            settle();
            `CHK("seg", 8'h01 << p[k], seg)
            `CHK("oe", 8'hFF & ~(8'h01 << p[k]), pins.oe)
        end
        wr8(5'h14, 8'h00);
    endtask : t_seg

    task automatic t_analog();
        logic [7:0] e;
        logic [2:0] pm [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5};
        wr8(5'h0C, 8'h00);
        settle();
        `CHK("oe", 8'hFF, pins.oe)
        `CHK("out", 8'h05, pins.out)
        wr8(5'h08, 8'hFF);
        ext_en <= 8'hFF;
        for (int f = 0; f < 16; f++) begin
            e = 8'h00;
            for (int k = 0; k < 5; k++) if (f < 15 - k) e[pm[k]] = 1'b1;
            wr8(5'h0C, 8'(f));
            settle();
            `CHK("ana", e, ana)
            rdchk(5'h0C, 8'(f));
            rdchk(5'h00, ~e);
        end
    endtask : t_analog

    task automatic t_osc();
        logic       o6, o7;
        logic [7:0] s;
        ext_en <= 8'h00;
        wr8(5'h04, 8'hC5);
        wr8(5'h08, 8'hBF);
        for (int m = 0; m < 9; m++) begin
            osc <= pag_pkg::pag_osc_t'(m[3:0]);
            o6 = m == 4 || m == 6 || m == 8;
            o7 = m == 7 || m == 8;
            settle();
            rdchk(5'h04, {o7, o6, 6'h05});
            rdchk(5'h08, {o7, 7'h3F});
            rdchk(5'h00, {o7, o6, 6'h3F});
            `CHK("oe67", 2'b01, pins.oe[7:6])
            if (!o6) begin
                for (int i = 0; i < 8; i++) begin
                    @(negedge ref_clk);
                    s[i] = pins.out[6];
                end
                `CHK("clk", s[7:4], s[3:0])
                `CHK("ones", 4, $countones(s))
            end
        end
    endtask : t_osc

    task automatic t_unmapped();
        bus(1'b0, 5'h18, 8'h00, d);
        `CHK("waits", 2, waits)
        `CHK("resp", 2'h2, resp)
        `CHK("rd", 8'h00, d)
        wr8(5'h18, 8'h3C);
        rdchk(5'h04, 8'hC5);
        `CHK("resp", 2'h0, resp)
    endtask : t_unmapped

    ////////////////////////////////////////////////////////////////////////
    initial begin
        num_errors = 0;
        cmp_count = 0;
        rst_b = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        adr = 5'h00;
        wdat = 32'h00000000;
        osc = pag_pkg::OSC_INT_IO_TWO;
        ext_en = 8'hFF;
        ext_val = 8'hFF;
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        t_reset();
        t_latch();
        t_seg();
        t_analog();
        t_osc();
        t_unmapped();
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        stop_test();
    end
endmodule : pag_port_tb

`default_nettype wire
